// ### hw/fcs_pkg.sv
// Constants and setup word layout for the fallback communication setup controller.
// Assumes a 10 MHz system clock and an external UART and reply formatter.
// Notes on behaviour
// RL1: Strap low forces 300 baud 8N1, any address.
// RL2: Entering fallback never writes stored setup.
// RL3: Fallback mode leaves every command enabled.
// RL4: Fallback allows readings and calibration writes.
// RL5: Four distinct channel addresses, all enabled fallback.
// RL6: Channel addresses are four consecutive ASCII codes.
// RL7: Fallback refuses NUL, CR, dollar, hash, braces.
// RL8: Host always sends an address character.
// RL9: Unknown address in fallback selects channel 0.
// RL10: Read setup reports stored word with address.
// RL11: Setup write changes storage, not fallback framing.
// RL12: Strap release causes program reset, stored framing.
// RL13: Read data reply opens with an asterisk.
// RL14: Factory setup: address 1, 300 baud, defaults.
// RL15: Setup and calibration kept in retained storage.
// RL16: Every setup value writable over serial port.
// RL17: Host uses fallback with one module only.
// RL18: Strap input synchronised and debounced first.
package fcs_pkg;
   // Setup word field positions.
   localparam int SW_W       = 22;
   localparam int SW_ADDR_LO = 0;
   localparam int SW_BAUD_LO = 8;
   localparam int SW_PAR_LO  = 12;
   localparam int SW_LF_BIT  = 14;
   localparam int SW_ALM_BIT = 15;
   localparam int SW_DLY_LO  = 16;
   localparam int SW_EN_LO   = 18;
   // Storage map: word 0 is setup, words 1 to 4 hold channel calibration.
   localparam int MEM_DEPTH  = 8;
   localparam int MEM_AW     = 3;
   localparam logic [2:0] MEM_SETUP_IDX = 3'h0;
   localparam logic [2:0] MEM_CAL_BASE  = 3'h1;
   // Codes.
   localparam logic [3:0] BAUD_300   = 4'h0;
   localparam logic [1:0] PAR_NONE   = 2'h0;
   localparam logic [7:0] FACT_ADDR  = 8'h31;
   localparam logic [1:0] FACT_DLY   = 2'h2;
   localparam logic [3:0] ALL_CHAN   = 4'hf;
   localparam logic [SW_W-1:0] FACT_SETUP =
      {ALL_CHAN, FACT_DLY, 1'b0, 1'b0, PAR_NONE, BAUD_300, FACT_ADDR};
   // Characters.
   localparam logic [7:0] CH_NUL   = 8'h00;
   localparam logic [7:0] CH_CR    = 8'h0d;
   localparam logic [7:0] CH_DOL   = 8'h24;
   localparam logic [7:0] CH_HASH  = 8'h23;
   localparam logic [7:0] CH_LBR   = 8'h7b;
   localparam logic [7:0] CH_RBR   = 8'h7d;
   localparam logic [7:0] CH_STAR  = 8'h2a;
   // Command kinds.
   localparam logic [1:0] CMD_READ_DATA  = 2'h0;
   localparam logic [1:0] CMD_READ_SETUP = 2'h1;
   localparam logic [1:0] CMD_SETUP_WR   = 2'h2;
   localparam logic [1:0] CMD_CAL_WR     = 2'h3;
   // Strap debounce time and its cycle count at 100 ns.
   localparam int CLK_NS      = 100;
   localparam int DEB_TIME_NS = 100000;
   localparam int DEB_CYC     = (DEB_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int DEB_W       = 10;
endpackage

// ### hw/fcs_setup_mem.sv
// Small retained store for the setup word and channel calibration words.
// Assumes the array sits in storage that survives power loss; reset clears read data only.
`timescale 1ns/1ps
`default_nettype none
module fcs_setup_mem (
   input  wire logic                         i_mclk,   // System clock.
   input  wire logic                         i_nrst,   // Async reset, active low.
   input  wire logic                         i_ce,     // Clock enable.
   input  wire logic                         i_we,     // Write strobe.
   input  wire logic [fcs_pkg::MEM_AW-1:0]   i_waddr,  // Write index.
   input  wire logic [fcs_pkg::SW_W-1:0]     i_wdata,  // Write word.
   input  wire logic                         i_re,     // Read strobe.
   input  wire logic [fcs_pkg::MEM_AW-1:0]   i_raddr,  // Read index.
   output logic      [fcs_pkg::SW_W-1:0]     o_rdata   // Registered read word.
);
   typedef struct packed {
      logic [fcs_pkg::MEM_DEPTH-1:0][fcs_pkg::SW_W-1:0] mem;
      logic [fcs_pkg::SW_W-1:0]                         rdata;
   } fcs_mem_t;
   fcs_mem_t q, d;

   // Write and read ports; reading the word being written returns the old value.
   always_comb begin
      d = q;
      if (i_we) begin
         d.mem[i_waddr] = i_wdata; // [RL15]
      end
      if (i_re) begin
         d.rdata = q.mem[i_raddr];
      end
   end

   // The array is kept out of reset on purpose so a reset never loses setup.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         q.rdata <= '0;
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign o_rdata = q.rdata;
endmodule
`default_nettype wire

// ### hw/fcs_ctrl.sv
// Top of the fallback communication setup controller.
// Assumes a UART that takes framing codes and a parser that hands over one decoded command.
`timescale 1ns/1ps
`default_nettype none
module fcs_ctrl (
   input  wire logic                     i_mclk,        // System clock, 10 MHz.
   input  wire logic                     i_nrst,        // Async reset, active low.
   input  wire logic                     i_ce,          // Clock enable, freezes state.
   input  wire logic                     i_default_n,   // Strap pin, low selects fallback.
   input  wire logic                     i_factory_ld,  // Load factory setup into storage.
   input  wire logic                     i_cmd_valid,   // Command strobe, one cycle.
   input  wire logic [7:0]               i_cmd_addr,    // Address character of command.
   input  wire logic [1:0]               i_cmd_kind,    // Command kind code.
   input  wire logic [fcs_pkg::SW_W-1:0] i_cmd_wdata,   // Setup or calibration word.
   output logic                          o_fallback,    // Fallback mode active.
   output logic [3:0]                    o_baud_code,   // Baud code for the UART.
   output logic [1:0]                    o_parity_code, // Parity code for the UART.
   output logic [3:0]                    o_chan_en,     // Channel enables.
   output logic                          o_prog_reset,  // Program reset pulse.
   output logic                          o_cmd_acc,     // Command accepted pulse.
   output logic                          o_cmd_rej,     // Command ignored pulse.
   output logic [1:0]                    o_cmd_chan,    // Channel of accepted command.
   output logic                          o_rd_req,      // Reading request pulse.
   output logic [7:0]                    o_rsp_lead,    // Lead character of data reply.
   output logic                          o_rsp_valid,   // Setup reply pulse.
   output logic [fcs_pkg::SW_W-1:0]      o_rsp_data     // Stored setup word reply.
);
   typedef enum logic [1:0] {
      ST_BOOT  = 2'b00,
      ST_LOAD  = 2'b01,
      ST_RUN   = 2'b11,
      ST_RESET = 2'b10
   } fcs_st_t;

   typedef struct packed {
      fcs_st_t                     st;
      logic [1:0]                  sync;
      logic                        deb;
      logic [fcs_pkg::DEB_W-1:0]   cnt;
      logic [3:0]                  act_baud;
      logic [1:0]                  act_par;
      logic [7:0]                  act_base;
      logic [3:0]                  act_en;
      logic                        rs_pend;
      logic                        fb;
      logic [3:0]                  baud;
      logic [1:0]                  par;
      logic [3:0]                  en;
      logic                        prst;
      logic                        acc;
      logic                        rej;
      logic [1:0]                  chan;
      logic                        rd_req;
      logic                        rsp_valid;
      logic [fcs_pkg::SW_W-1:0]    rsp_data;
      logic [7:0]                  lead;
   } fcs_ctrl_t;

   fcs_ctrl_t q, d;
   logic                         mem_we;
   logic [fcs_pkg::MEM_AW-1:0]   mem_waddr;
   logic [fcs_pkg::SW_W-1:0]     mem_wdata;
   logic                         mem_re;
   logic [fcs_pkg::SW_W-1:0]     mem_rdata;

   // Characters that can never serve as an address.
   function automatic logic addr_illegal(input logic [7:0] c);
      return (c == fcs_pkg::CH_NUL) || (c == fcs_pkg::CH_CR) ||
             (c == fcs_pkg::CH_DOL) || (c == fcs_pkg::CH_HASH) ||
             (c == fcs_pkg::CH_LBR) || (c == fcs_pkg::CH_RBR); // [RL7]
   endfunction

   // Offset of a character from the first channel address; wraps for lower codes.
   function automatic logic [7:0] addr_off(input logic [7:0] c, input logic [7:0] base);
      return c - base; // [RL6]
   endfunction

   fcs_setup_mem fcs_setup_mem_i (
      .i_mclk  (i_mclk),
      .i_nrst  (i_nrst),
      .i_ce    (i_ce),
      .i_we    (mem_we),
      .i_waddr (mem_waddr),
      .i_wdata (mem_wdata),
      .i_re    (mem_re),
      .i_raddr (fcs_pkg::MEM_SETUP_IDX),
      .o_rdata (mem_rdata)
   );

   // Next-state logic for strap handling, setup loading and command dispatch.
   always_comb begin
      logic [7:0] off;
      logic       in_range;
      logic       legal;
      logic       take;
      logic [1:0] ch;
      off       = addr_off(i_cmd_addr, q.act_base);
      in_range  = (off < 8'h04);
      legal     = !addr_illegal(i_cmd_addr);
      take      = 1'b0;
      ch        = 2'h0;
      d         = q;
      d.prst    = 1'b0;
      d.acc     = 1'b0;
      d.rej     = 1'b0;
      d.rd_req  = 1'b0;
      d.rsp_valid = 1'b0;
      d.rs_pend = 1'b0;
      mem_we    = 1'b0;
      mem_waddr = fcs_pkg::MEM_SETUP_IDX;
      mem_wdata = i_cmd_wdata;
      mem_re    = 1'b0;

      // Two-stage sync, then the level must hold for the whole debounce time.
      d.sync = {q.sync[0], i_default_n};
      if (q.sync[1] != q.deb) begin
         if (q.cnt == fcs_pkg::DEB_W'(fcs_pkg::DEB_CYC - 1)) begin
            d.deb = q.sync[1]; // [RL18]
            d.cnt = '0;
         end else begin
            d.cnt = q.cnt + 1'b1;
         end
      end else begin
         d.cnt = '0;
      end

      unique case (q.st)
         ST_BOOT: begin
            mem_re = 1'b1;
            d.st   = ST_LOAD;
         end
         ST_LOAD: begin
            // Stored framing becomes active only here, right after an async reset or a program reset.
            d.act_base = mem_rdata[fcs_pkg::SW_ADDR_LO +: 8];
            d.act_baud = mem_rdata[fcs_pkg::SW_BAUD_LO +: 4]; // [RL12]
            d.act_par  = mem_rdata[fcs_pkg::SW_PAR_LO +: 2];
            d.act_en   = mem_rdata[fcs_pkg::SW_EN_LO +: 4];
            d.st       = ST_RUN;
         end
         ST_RUN: begin
            if (q.deb && !q.fb) begin
               take = legal && in_range && q.act_en[off[1:0]];
               ch   = off[1:0];
            end else begin
               take = legal; // [RL1] [RL3] [RL4]
               ch   = in_range ? off[1:0] : 2'h0; // [RL9] [RL5]
            end
            if (q.deb && q.fb) begin
               d.prst = 1'b1; // [RL12]
               d.st   = ST_RESET;
            end else if (i_factory_ld) begin
               mem_we    = 1'b1;
               mem_wdata = fcs_pkg::FACT_SETUP; // [RL14]
            end else if (i_cmd_valid) begin
               d.acc  = take;
               d.rej  = !take;
               d.chan = ch;
               if (take) begin
                  unique case (i_cmd_kind)
                     fcs_pkg::CMD_READ_DATA: d.rd_req = 1'b1; // [RL13]
                     fcs_pkg::CMD_READ_SETUP: begin
                        mem_re    = 1'b1;
                        d.rs_pend = 1'b1;
                     end
                     fcs_pkg::CMD_SETUP_WR: begin
                        mem_we = 1'b1; // [RL11] [RL16]
                     end
                     fcs_pkg::CMD_CAL_WR: begin
                        mem_we    = 1'b1; // [RL4]
                        mem_waddr = fcs_pkg::MEM_CAL_BASE + {1'b0, ch};
                     end
                  endcase
               end
            end
         end
         ST_RESET: begin
            d.st = ST_BOOT;
         end
      endcase

      // The read setup reply carries the stored word, first address included.
      if (q.rs_pend) begin
         d.rsp_valid = 1'b1; // [RL10]
         d.rsp_data  = mem_rdata;
      end

      // Fallback framing is fixed and never touches storage, so the stored word survives.
      d.fb   = !q.deb; // [RL2]
      d.baud = !q.deb ? fcs_pkg::BAUD_300 : q.act_baud; // [RL1] [RL11]
      d.par  = !q.deb ? fcs_pkg::PAR_NONE : q.act_par;
      d.en   = !q.deb ? fcs_pkg::ALL_CHAN : q.act_en; // [RL5]
   end

   // State register; the strap level starts as released so boot uses stored setup.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         q          <= '0;
         q.st       <= ST_BOOT;
         q.sync     <= 2'b11;
         q.deb      <= 1'b1;
         q.act_base <= fcs_pkg::FACT_ADDR;
         q.act_en   <= fcs_pkg::ALL_CHAN;
         q.en       <= fcs_pkg::ALL_CHAN;
         q.lead     <= fcs_pkg::CH_STAR; // [RL13]
      end else if (i_ce) begin
         q <= d;
      end
   end

   assign o_fallback    = q.fb;
   assign o_baud_code   = q.baud;
   assign o_parity_code = q.par;
   assign o_chan_en     = q.en;
   assign o_prog_reset  = q.prst;
   assign o_cmd_acc     = q.acc;
   assign o_cmd_rej     = q.rej;
   assign o_cmd_chan    = q.chan;
   assign o_rd_req      = q.rd_req;
   assign o_rsp_lead    = q.lead; // Lead character of every data reply, held in a flop.
   assign o_rsp_valid   = q.rsp_valid;
   assign o_rsp_data    = q.rsp_data;
endmodule
`default_nettype wire

// ### tb/fcs_ctrl_properties.sv
// Concurrent checks on the ports of the fallback communication setup controller.
// Assumes it is bound to fcs_ctrl, with one clock and an active-low async reset.
`timescale 1ns/1ps
`default_nettype none
module fcs_ctrl_props (
   input wire logic       i_mclk,        // System clock.
   input wire logic       i_nrst,        // Async reset, active low.
   input wire logic       i_ce,          // Clock enable.
   input wire logic       i_default_n,   // Raw strap pin.
   input wire logic       i_factory_ld,  // Factory load request.
   input wire logic       i_cmd_valid,   // Command strobe.
   input wire logic [7:0] i_cmd_addr,    // Address character.
   input wire logic [1:0] i_cmd_kind,    // Command kind.
   input wire logic       o_fallback,    // Fallback active.
   input wire logic [3:0] o_baud_code,   // Live baud code.
   input wire logic [1:0] o_parity_code, // Live parity code.
   input wire logic [3:0] o_chan_en,     // Channel enables.
   input wire logic       o_prog_reset,  // Program reset pulse.
   input wire logic       o_cmd_acc,     // Command accepted.
   input wire logic       o_rd_req,      // Reading request.
   input wire logic       o_rsp_valid    // Setup reply strobe.
);
   logic [10:0] strap_low_q; // Saturating count of cycles the raw strap has been low.
   logic        illegal;     // Address character that no mode may accept.

   // The six characters that are refused whatever the mode.
   assign illegal = i_cmd_addr inside {8'h00, 8'h0d, 8'h24, 8'h23, 8'h7b, 8'h7d};

   // Counts raw pin time so debounce can be judged without seeing internal state.
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         strap_low_q <= 11'h000;
      end else if (i_default_n) begin
         strap_low_q <= 11'h000;
      end else if (strap_low_q != 11'h7ff) begin
         strap_low_q <= strap_low_q + 11'h001;
      end
   end

   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);

   // Steps of a read-setup exchange and of the strap release.
   sequence setup_read_taken;
      i_cmd_valid && i_cmd_kind == 2'h1 ##1 o_cmd_acc;
   endsequence
   sequence fallback_drop;
      o_fallback ##1 !o_fallback;
   endsequence

   chk_illegal_refused: assert property (i_cmd_valid && illegal |=> !o_cmd_acc)
      else $error("illegal address accepted");
   chk_fallback_framing: assert property (o_fallback && $past(o_fallback) |->
      o_baud_code == 4'h0 && o_parity_code == 2'h0 && o_chan_en == 4'hf)
      else $error("fallback framing wrong");
   chk_fallback_any_addr: assert property (o_fallback && strap_low_q > 11'h004 &&
      i_cmd_valid && i_ce && !i_factory_ld && !illegal |=> o_cmd_acc)
      else $error("fallback command not accepted");
   chk_rdreq_with_acc: assert property (o_rd_req |-> o_cmd_acc)
      else $error("reading request without accept");
   chk_read_data_req: assert property (i_cmd_valid && i_cmd_kind == 2'h0 ##1 o_cmd_acc
      |-> o_rd_req)
      else $error("read data gave no request");
   chk_setup_reply: assert property (setup_read_taken |=> o_rsp_valid)
      else $error("read setup gave no reply");
   chk_release_reset: assert property (fallback_drop |-> o_prog_reset)
      else $error("fallback dropped without program reset");
   chk_reset_cause: assert property (o_prog_reset |-> !o_fallback && $past(o_fallback))
      else $error("program reset outside strap release");
   chk_strap_debounce: assert property ($rose(o_fallback) |-> strap_low_q >= 11'h3e8)
      else $error("fallback entered before debounce");
endmodule
bind fcs_ctrl fcs_ctrl_props fcs_ctrl_props_i (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_ce(i_ce),
   .i_default_n(i_default_n), .i_factory_ld(i_factory_ld), .i_cmd_valid(i_cmd_valid),
   .i_cmd_addr(i_cmd_addr), .i_cmd_kind(i_cmd_kind), .o_fallback(o_fallback),
   .o_baud_code(o_baud_code), .o_parity_code(o_parity_code), .o_chan_en(o_chan_en),
   .o_prog_reset(o_prog_reset), .o_cmd_acc(o_cmd_acc), .o_rd_req(o_rd_req),
   .o_rsp_valid(o_rsp_valid));
`default_nettype wire

// ### tb/fcs_host.sv
// Host terminal model that issues one addressed command at a time.
// Assumes the bench calls send from a single process and reads the results after it.
`timescale 1ns/1ps
`default_nettype none
module fcs_host (
   input  wire logic                     i_mclk,      // System clock.
   input  wire logic                     i_acc,       // Command accepted.
   input  wire logic                     i_rej,       // Command ignored.
   input  wire logic [1:0]               i_chan,      // Channel of command.
   input  wire logic                     i_rd_req,    // Reading request.
   input  wire logic                     i_rsp_valid, // Setup reply strobe.
   input  wire logic [fcs_pkg::SW_W-1:0] i_rsp_data,  // Setup reply word.
   output logic                          o_valid,     // Command strobe.
   output logic [7:0]                    o_addr,      // Address character.
   output logic [1:0]                    o_kind,      // Command kind.
   output logic [fcs_pkg::SW_W-1:0]      o_wdata      // Write word.
);
   logic [3:0]               got = 4'h0;  // Seen {reply, request, ignored, accepted}.
   logic [1:0]               chan = 2'h0; // Channel reported with the answer.
   logic [fcs_pkg::SW_W-1:0] rsp = '0;    // Last setup reply word.

   initial o_valid = 1'b0;
   initial o_addr = 8'h31;
   initial o_kind = 2'h0;
   initial o_wdata = '0;

   // Every command carries an address, a dummy one in fallback too; idle address and data lines are inverted
   // so a design that samples them outside the strobe sees garbage.
   task automatic send(input logic [7:0] a, input logic [1:0] k,
                       input logic [fcs_pkg::SW_W-1:0] w);
      got = 4'h0;
      @(posedge i_mclk);
      o_valid <= 1'b1;
      o_addr <= a;
      o_kind <= k;
      o_wdata <= w;
      @(posedge i_mclk);
      o_valid <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~w;
      repeat (3) begin
         #1;
         got = got | {i_rsp_valid, i_rd_req, i_rej, i_acc};
         if (i_acc || i_rej) chan = i_chan;
         if (i_rsp_valid) rsp = i_rsp_data;
         @(posedge i_mclk);
      end
   endtask
endmodule
`default_nettype wire

// ### tb/fcs_ctrl_bench.sv
// Self-checking bench for the fallback communication setup controller.
// Assumes the checker is bound from its own file and the host model drives commands.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
   $display("Error t=%0t got=%h exp=%h", $time, (g), (e)); end end
module fcs_ctrl_bench;
   logic                     mclk = 1'b0, nrst = 1'b0, ce = 1'b1, strap_n = 1'b1;
   logic                     fact_ld = 1'b0, cmd_valid, fb, prst, acc, rej, rd_req, rsp_valid;
   logic [7:0]               cmd_addr, lead;
   logic [1:0]               cmd_kind, par, chan;
   logic [3:0]               baud, chan_en;
   logic [fcs_pkg::SW_W-1:0] cmd_wdata, rsp_data;
   int                       miscompares = 0, samples_checked = 0, cycles = 0;

   // Only one module sits on the host line, as fallback mode needs.
   fcs_ctrl fcs_ctrl_i (.i_mclk(mclk), .i_nrst(nrst), .i_ce(ce), .i_default_n(strap_n),
      .i_factory_ld(fact_ld), .i_cmd_valid(cmd_valid), .i_cmd_addr(cmd_addr),
      .i_cmd_kind(cmd_kind), .i_cmd_wdata(cmd_wdata), .o_fallback(fb), .o_baud_code(baud),
      .o_parity_code(par), .o_chan_en(chan_en), .o_prog_reset(prst), .o_cmd_acc(acc),
      .o_cmd_rej(rej), .o_cmd_chan(chan), .o_rd_req(rd_req), .o_rsp_lead(lead),
      .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data));
   fcs_host fcs_host_i (.i_mclk(mclk), .i_acc(acc), .i_rej(rej), .i_chan(chan),
      .i_rd_req(rd_req), .i_rsp_valid(rsp_valid), .i_rsp_data(rsp_data), .o_valid(cmd_valid),
      .o_addr(cmd_addr), .o_kind(cmd_kind), .o_wdata(cmd_wdata));

   // Clock and a hang limit well above the roughly 2200 cycles the tests need.
   always #50 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 8000) begin
         miscompares++;
         final_report();
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Factory word stored, then a reset proves it is retained and applied.
   task automatic t_factory();
      cyc(1);
      fact_ld <= 1'b1;
      cyc(1);
      fact_ld <= 1'b0;
      nrst <= 1'b0;
      cyc(2);
      nrst <= 1'b1;
      cyc(3);
      #1;
      `CHK({fb, baud, par, chan_en}, {1'b0, 4'h0, 2'h0, 4'hf})
      fcs_host_i.send(8'h31, fcs_pkg::CMD_READ_SETUP, 22'h000000);
      `CHK(fcs_host_i.rsp, 22'h3e0031)
      $display("test factory done");
   endtask

   // Normal mode decodes only the four consecutive addresses from the base.
   task automatic t_normal();
      logic [7:0] a [4] = '{8'h32, 8'h34, 8'h35, 8'h30};
      logic [3:0] e [4] = '{4'h5, 4'h5, 4'h2, 4'h2};
      for (int i = 0; i < 4; i++) begin
         fcs_host_i.send(a[i], fcs_pkg::CMD_READ_DATA, 22'h000000);
         `CHK(fcs_host_i.got, e[i])
         if (i < 2) `CHK(fcs_host_i.chan, 2'(2 * i + 1))
      end
      `CHK(lead, 8'h2a)
      // A frozen block must not take a command while the clock enable is low.
      ce <= 1'b0;
      fcs_host_i.send(8'h31, fcs_pkg::CMD_READ_DATA, 22'h000000);
      `CHK(fcs_host_i.got, 4'h0)
      ce <= 1'b1;
      fcs_host_i.send(8'h31, fcs_pkg::CMD_SETUP_WR, 22'h3d1541);
      `CHK(fcs_host_i.got, 4'h1)
      $display("test normal done");
   endtask

   // Fallback: fixed framing, stored word intact, any legal address taken.
   task automatic t_fallback();
      logic [7:0] bad [6] = '{8'h00, 8'h0d, 8'h24, 8'h23, 8'h7b, 8'h7d};
      strap_n <= 1'b0;
      cyc(500);
      `CHK(fb, 1'b0)
      cyc(600);
      #1;
      `CHK({fb, baud, par, chan_en}, {1'b1, 4'h0, 2'h0, 4'hf})
      fcs_host_i.send(8'h58, fcs_pkg::CMD_READ_SETUP, 22'h000000);
      `CHK(fcs_host_i.rsp, 22'h3d1541)
      foreach (bad[i]) begin
         fcs_host_i.send(bad[i], fcs_pkg::CMD_READ_DATA, 22'h000000);
         `CHK(fcs_host_i.got, 4'h2)
      end
      fcs_host_i.send(8'h7a, fcs_pkg::CMD_READ_DATA, 22'h000000);
      `CHK({fcs_host_i.got, fcs_host_i.chan}, {4'h5, 2'h0})
      fcs_host_i.send(8'h33, fcs_pkg::CMD_READ_DATA, 22'h000000);
      `CHK({fcs_host_i.got, fcs_host_i.chan}, {4'h5, 2'h2})
      fcs_host_i.send(8'h32, fcs_pkg::CMD_CAL_WR, 22'h012345);
      `CHK({fcs_host_i.got, fcs_host_i.chan}, {4'h1, 2'h1})
      fcs_host_i.send(8'h5a, fcs_pkg::CMD_SETUP_WR, 22'h3e2331);
      `CHK({fcs_host_i.got, baud, par}, {4'h1, 4'h0, 2'h0})
      $display("test fallback done");
   endtask

   // Release: debounced, then program reset and the stored framing.
   task automatic t_release();
      int n;
      strap_n <= 1'b1;
      for (n = 0; n < 1200 && prst !== 1'b1; n++) begin
         @(posedge mclk);
         #1;
      end
      `CHK({n > 990, prst}, 2'h3)
      cyc(8);
      #1;
      `CHK({fb, baud, par}, {1'b0, 4'h3, 2'h2})
      fcs_host_i.send(8'h31, fcs_pkg::CMD_READ_DATA, 22'h000000);
      `CHK({fcs_host_i.got, fcs_host_i.chan}, {4'h5, 2'h0})
      $display("test release done");
   endtask

   initial begin
      cyc(2);
      nrst <= 1'b1;
      cyc(3);
      t_factory();
      t_normal();
      t_fallback();
      t_release();
      final_report();
   end
endmodule
`default_nettype wire
